// ==== design/ate_pkg.sv ====
// Shared constants and types for the accumulator transfer executor
package ate_pkg;

    // Datapath widths
    localparam int unsigned ACC_W     = 4;
    localparam int unsigned E_W       = 8;
    localparam int unsigned D_W       = 3;
    localparam int unsigned SP_W      = 3;
    localparam int unsigned Z_W       = 2;
    localparam int unsigned OP_W      = 5;
    localparam int unsigned ADDR_W    = 6;
    localparam int unsigned DATA_W    = 32;
    localparam int unsigned MEM_AW    = 5;
    localparam int unsigned MEM_DEPTH = 17;

    // Avalon word addresses
    localparam logic [ADDR_W-1:0] ADR_OPCODE   = 6'h00;
    localparam logic [ADDR_W-1:0] ADR_ACC      = 6'h01;
    localparam logic [ADDR_W-1:0] ADR_B        = 6'h02;
    localparam logic [ADDR_W-1:0] ADR_E        = 6'h03;
    localparam logic [ADDR_W-1:0] ADR_D        = 6'h04;
    localparam logic [ADDR_W-1:0] ADR_X        = 6'h05;
    localparam logic [ADDR_W-1:0] ADR_Y        = 6'h06;
    localparam logic [ADDR_W-1:0] ADR_Z        = 6'h07;
    localparam logic [ADDR_W-1:0] ADR_SP       = 6'h08;
    localparam logic [ADDR_W-1:0] ADR_STATUS   = 6'h09;
    localparam logic [ADDR_W-1:0] ADR_CTL_BASE = 6'h20;
    localparam logic [ADDR_W-1:0] ADR_CTL_LAST = 6'h30;

    // Control register file entries
    localparam logic [MEM_AW-1:0] MEM_V1  = 5'h00;
    localparam logic [MEM_AW-1:0] MEM_W1  = 5'h02;
    localparam logic [MEM_AW-1:0] MEM_FR0 = 5'h08;
    localparam logic [MEM_AW-1:0] MEM_I1  = 5'h0b;
    localparam logic [MEM_AW-1:0] MEM_K0  = 5'h0d;
    localparam logic [MEM_AW-1:0] MEM_L1  = 5'h10;

    // Status register bit positions
    localparam int unsigned STS_CY_BIT   = 0;
    localparam int unsigned STS_SKIP_BIT = 1;
    localparam int unsigned STS_ERR_BIT  = 2;

    // Reset values
    localparam logic [ACC_W-1:0]  RST_NIB  = 4'h0;
    localparam logic [E_W-1:0]    RST_E    = 8'h00;
    localparam logic [D_W-1:0]    RST_D    = 3'h0;
    localparam logic [Z_W-1:0]    RST_Z    = 2'h0;
    localparam logic [DATA_W-1:0] RST_DATA = 32'h0000_0000;

    // Transfer instructions
    typedef enum logic [OP_W-1:0] {
        op_nop                 = 5'h00,
        op_read_stack_ptr      = 5'h01,
        op_read_z_pointer      = 5'h02,
        op_read_x_pointer      = 5'h03,
        op_read_y_pointer      = 5'h04,
        op_write_b_reg         = 5'h05,
        op_write_d_pointer     = 5'h06,
        op_write_e_reg         = 5'h07,
        op_read_irq_enable_1   = 5'h08,
        op_read_irq_enable_2   = 5'h09,
        op_read_timer_ctl_1    = 5'h0a,
        op_read_timer_ctl_2    = 5'h0b,
        op_read_timer_ctl_3    = 5'h0c,
        op_read_timer_ctl_4    = 5'h0d,
        op_read_timer_ctl_5    = 5'h0e,
        op_read_timer_ctl_6    = 5'h0f,
        op_write_port_struct_0 = 5'h10,
        op_write_port_struct_1 = 5'h11,
        op_write_port_struct_2 = 5'h12,
        op_write_irq_source_1  = 5'h13,
        op_write_irq_source_2  = 5'h14,
        op_write_wakeup_ctl_0  = 5'h15,
        op_write_wakeup_ctl_1  = 5'h16,
        op_write_wakeup_ctl_2  = 5'h17,
        op_write_lcd_ctl_1     = 5'h18
    } ate_op_t;

    // Accumulator source selection
    typedef enum logic [2:0] {
        SRC_NONE = 3'b000,
        SRC_SP   = 3'b001,
        SRC_Z    = 3'b010,
        SRC_X    = 3'b011,
        SRC_Y    = 3'b100,
        SRC_MEM  = 3'b101
    } ate_src_t;

    // Decoded instruction
    typedef struct packed {
        logic              legal;
        ate_src_t          acc_src;
        logic              wr_b;
        logic              wr_d;
        logic              wr_e;
        logic              mem_wr;
        logic [MEM_AW-1:0] mem_idx;
    } ate_dec_t;

    // Bus access sequencer
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_FETCH = 2'b01,
        ST_EXEC  = 2'b10,
        ST_ACK   = 2'b11
    } ate_state_t;

endpackage : ate_pkg

// ==== design/ate_ctl_mem.sv ====
// Control register file with one write port and a registered read port
module ate_ctl_mem #(
    parameter int unsigned WIDTH = 4,
    parameter int unsigned DEPTH = 17,
    parameter int unsigned AW    = 5
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic             ce,
    input  wire logic             we,
    input  wire logic [AW-1:0]    waddr,
    input  wire logic [WIDTH-1:0] wdata,
    input  wire logic [AW-1:0]    raddr,
    output logic      [WIDTH-1:0] rdata_q
);
    import ate_pkg::*;

    logic [WIDTH-1:0] mem_q [DEPTH];

    // One flop group per entry, cleared at reset
    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++) begin : g_ent
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    mem_q[gi] <= '0;
                end else if (ce && we && (waddr == AW'(gi))) begin
                    mem_q[gi] <= wdata;
                end
            end
        end
    endgenerate

    // Out-of-range reads return zero
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= '0;
        end else if (ce) begin
            rdata_q <= (raddr < AW'(DEPTH)) ? mem_q[raddr] : '0;
        end
    end

endmodule : ate_ctl_mem

// ==== design/ate_dec.sv ====
// Instruction decoder for the accumulator transfer group
module ate_dec (
    input  ate_pkg::ate_op_t  op,
    output ate_pkg::ate_dec_t dec
);
    import ate_pkg::*;

    // Instruction classes
    wire is_rd_irq  = (op == op_read_irq_enable_1) || (op == op_read_irq_enable_2);
    wire is_rd_tmr  = (op >= op_read_timer_ctl_1) && (op <= op_read_timer_ctl_6);
    wire is_wr_port = (op >= op_write_port_struct_0) && (op <= op_write_port_struct_2);
    wire is_wr_isrc = (op == op_write_irq_source_1) || (op == op_write_irq_source_2);
    wire is_wr_wake = (op >= op_write_wakeup_ctl_0) && (op <= op_write_wakeup_ctl_2);
    wire is_wr_lcd  = (op == op_write_lcd_ctl_1);
    wire is_mem_wr  = is_wr_port || is_wr_isrc || is_wr_wake || is_wr_lcd;

    // Control register index from the instruction's position in its class
    wire [MEM_AW-1:0] idx_irq  = MEM_V1 + MEM_AW'(op - op_read_irq_enable_1);
    wire [MEM_AW-1:0] idx_tmr  = MEM_W1 + MEM_AW'(op - op_read_timer_ctl_1);
    wire [MEM_AW-1:0] idx_port = MEM_FR0 + MEM_AW'(op - op_write_port_struct_0);
    wire [MEM_AW-1:0] idx_isrc = MEM_I1 + MEM_AW'(op - op_write_irq_source_1);
    wire [MEM_AW-1:0] idx_wake = MEM_K0 + MEM_AW'(op - op_write_wakeup_ctl_0);

    assign dec.mem_idx = is_rd_irq  ? idx_irq  :
                         is_rd_tmr  ? idx_tmr  :
                         is_wr_port ? idx_port :
                         is_wr_isrc ? idx_isrc :
                         is_wr_wake ? idx_wake :
                         MEM_L1;

    // Accumulator source for read instructions
    assign dec.acc_src = (op == op_read_stack_ptr) ? SRC_SP :
                         (op == op_read_z_pointer) ? SRC_Z  :
                         (op == op_read_x_pointer) ? SRC_X  :
                         (op == op_read_y_pointer) ? SRC_Y  :
                         (is_rd_irq || is_rd_tmr)  ? SRC_MEM : SRC_NONE;

    assign dec.wr_b   = (op == op_write_b_reg);
    assign dec.wr_d   = (op == op_write_d_pointer);
    assign dec.wr_e   = (op == op_write_e_reg);
    assign dec.mem_wr = is_mem_wr;
    assign dec.legal  = (op <= op_write_lcd_ctl_1);

endmodule : ate_dec

// ==== design/ate_xfer_exec.sv ====
// Accumulator transfer executor with an Avalon-MM register slave
//
// Function
// - Reading the Z pointer puts its two bits in accumulator bits 1..0 and zeroes bits 3..2.
// - Reading the X pointer loads all four of its bits into the accumulator.
// - Reading the Y pointer loads all four of its bits into the accumulator.
// - Writing the D pointer copies accumulator bits 2..0 and ignores bit 3.
// - Writing register E puts register B in its upper nibble and the accumulator below.
// - Writing register B copies the whole accumulator into it.
// - Two reads copy interrupt-enable register 1 or 2 into the accumulator.
// - Six reads copy one of the six timer control registers into the accumulator.
// - Three writes copy the accumulator into one of the port output-structure registers.
// - Two writes copy the accumulator into interrupt-source register 1 or 2.
// - Three writes copy the accumulator into one of the key-on wakeup registers.
// - One write copies the accumulator into LCD control register 1.
//
// Each access is taken in idle and answered after three wait cycles.
// Waitrequest drops for one cycle; instr_done pulses then for a legal opcode.
// Writes land on the edge that starts that ack, so the exports already show them.
// Holding ce low freezes all state, the control entries included.
// Unmapped addresses read zero and drop writes.
//
// Our own choices: the Avalon-MM slave port and the register offsets.
module ate_xfer_exec (
    input  wire logic                         clk_sys,
    input  wire logic                         rst_n,
    input  wire logic                         ce,
    input  wire logic [ate_pkg::ADDR_W-1:0]   avs_address,
    input  wire logic                         avs_read,
    input  wire logic                         avs_write,
    input  wire logic [ate_pkg::DATA_W-1:0]   avs_writedata,
    input  wire logic [3:0]                   avs_byteenable,
    output logic      [ate_pkg::DATA_W-1:0]   avs_readdata,
    output logic                              avs_waitrequest,
    output logic      [ate_pkg::ACC_W-1:0]    acc_val,
    output logic      [ate_pkg::ACC_W-1:0]    b_val,
    output logic      [ate_pkg::E_W-1:0]      e_val,
    output logic      [ate_pkg::D_W-1:0]      d_ptr_val,
    output logic                              instr_done
);
    import ate_pkg::*;

    // Architectural state
    ate_state_t        state_q, state_d;
    logic [ACC_W-1:0]  acc_q, acc_d;
    logic [ACC_W-1:0]  b_q, b_d;
    logic [E_W-1:0]    e_q, e_d;
    logic [D_W-1:0]    d_q, d_d;

    // Pointers, loaded over the bus in place of the rest of the core
    logic [ACC_W-1:0]  x_q, x_d;
    logic [ACC_W-1:0]  y_q, y_d;
    logic [Z_W-1:0]    z_q, z_d;
    logic [SP_W-1:0]   sp_q, sp_d;

    // Status, readback and sequencer
    logic              cy_q, cy_d;
    logic              err_q, err_d;
    ate_op_t           op_q, op_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic              wait_q, wait_d;
    logic              done_q, done_d;

    // Decoder and control register file wiring
    ate_op_t           bus_op;
    ate_dec_t          dec;
    logic [ACC_W-1:0]  mem_rdata;

    // Read and result paths
    logic [ACC_W-1:0]  src_val;
    logic [DATA_W-1:0] rd_val;

    // Opcode field of a write; unknown codes fall out as illegal
    assign bus_op = ate_op_t'(avs_writedata[OP_W-1:0]);

    // Decode is combinational on the write data lines
    ate_dec u_dec (
        .op  (bus_op),
        .dec (dec)
    );

    // Bus access classification
    wire req       = avs_read || avs_write;
    wire in_exec   = (state_q == ST_EXEC);
    wire lane0     = avs_byteenable[0];
    wire wr_en     = in_exec && avs_write && lane0;
    wire rd_en     = in_exec && avs_read;
    wire is_ctl    = (avs_address >= ADR_CTL_BASE) && (avs_address <= ADR_CTL_LAST);
    wire [MEM_AW-1:0] ctl_idx = MEM_AW'(avs_address - ADR_CTL_BASE);

    // Opcode writes; an illegal code raises the error flag and executes nothing
    wire do_op     = wr_en && (avs_address == ADR_OPCODE);
    wire op_ok     = do_op && dec.legal;
    wire op_bad    = do_op && !dec.legal;

    // Per-register bus write strobes
    wire bw_acc    = wr_en && (avs_address == ADR_ACC);
    wire bw_b      = wr_en && (avs_address == ADR_B);
    wire bw_e      = wr_en && (avs_address == ADR_E);
    wire bw_d      = wr_en && (avs_address == ADR_D);

    // Pointer and status loads
    wire bw_x      = wr_en && (avs_address == ADR_X);
    wire bw_y      = wr_en && (avs_address == ADR_Y);
    wire bw_z      = wr_en && (avs_address == ADR_Z);
    wire bw_sp     = wr_en && (avs_address == ADR_SP);
    wire bw_sts    = wr_en && (avs_address == ADR_STATUS);
    wire bw_ctl    = wr_en && is_ctl;

    // Read port follows the held request, so data is ready by the exec cycle
    wire [MEM_AW-1:0] mem_raddr = (avs_write && avs_address == ADR_OPCODE) ? dec.mem_idx
                                                                            : ctl_idx;

    // Instruction writes take precedence; bus writes preload control values
    wire              mem_we    = (op_ok && dec.mem_wr) || bw_ctl;
    wire [MEM_AW-1:0] mem_waddr = op_ok ? dec.mem_idx : ctl_idx;
    wire [ACC_W-1:0]  mem_wdata = op_ok ? acc_q : avs_writedata[ACC_W-1:0];

    // Control entries keep their own registered read port
    ate_ctl_mem #(
        .WIDTH (ACC_W),
        .DEPTH (MEM_DEPTH),
        .AW    (MEM_AW)
    ) u_ctl_mem (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .ce      (ce),
        .we      (mem_we),
        .waddr   (mem_waddr),
        .wdata   (mem_wdata),
        .raddr   (mem_raddr),
        .rdata_q (mem_rdata)
    );

    // Accumulator source value for read instructions
    always_comb begin
        case (dec.acc_src)
            SRC_SP:  src_val = ACC_W'(sp_q);
            SRC_Z:   src_val = ACC_W'(z_q);
            SRC_X:   src_val = x_q;
            SRC_Y:   src_val = y_q;
            SRC_MEM: src_val = mem_rdata;
            default: src_val = acc_q;
        endcase
    end

    // Next values of the working registers
    assign acc_d = (op_ok && dec.acc_src != SRC_NONE) ? src_val :
                   bw_acc ? avs_writedata[ACC_W-1:0] : acc_q;
    assign b_d   = (op_ok && dec.wr_b) ? acc_q :
                   bw_b ? avs_writedata[ACC_W-1:0] : b_q;
    assign e_d   = (op_ok && dec.wr_e) ? {b_q, acc_q} :
                   bw_e ? avs_writedata[E_W-1:0] : e_q;
    assign d_d   = (op_ok && dec.wr_d) ? acc_q[D_W-1:0] :
                   bw_d ? avs_writedata[D_W-1:0] : d_q;

    // Pointer loads stand in for the rest of the core
    assign x_d   = bw_x  ? avs_writedata[ACC_W-1:0] : x_q;
    assign y_d   = bw_y  ? avs_writedata[ACC_W-1:0] : y_q;
    assign z_d   = bw_z  ? avs_writedata[Z_W-1:0]   : z_q;
    assign sp_d  = bw_sp ? avs_writedata[SP_W-1:0]  : sp_q;

    // Carry only moves on a status write, never on a transfer
    assign cy_d  = bw_sts ? avs_writedata[STS_CY_BIT] : cy_q;

    // Illegal opcode flag: sticky, cleared by writing one; a set wins
    assign err_d = op_bad ? 1'h1 :
                   (bw_sts && avs_writedata[STS_ERR_BIT]) ? 1'h0 : err_q;

    // Readback keeps the last code written, legal or not
    assign op_d  = do_op ? bus_op : op_q;

    // Read mux; status skip bit is always zero since no transfer skips
    always_comb begin
        rd_val = RST_DATA;
        if (is_ctl) begin
            rd_val = DATA_W'(mem_rdata);
        end else begin
            case (avs_address)
                ADR_OPCODE: rd_val = DATA_W'(op_q);
                ADR_ACC:    rd_val = DATA_W'(acc_q);
                ADR_B:      rd_val = DATA_W'(b_q);
                ADR_E:      rd_val = DATA_W'(e_q);
                ADR_D:      rd_val = DATA_W'(d_q);
                ADR_X:      rd_val = DATA_W'(x_q);
                ADR_Y:      rd_val = DATA_W'(y_q);
                ADR_Z:      rd_val = DATA_W'(z_q);
                ADR_SP:     rd_val = DATA_W'(sp_q);
                ADR_STATUS: begin
                    rd_val[STS_CY_BIT]   = cy_q;
                    rd_val[STS_SKIP_BIT] = 1'h0;
                    rd_val[STS_ERR_BIT]  = err_q;
                end
                default:    rd_val = RST_DATA;
            endcase
        end
    end

    // Read data is taken once, in the exec cycle, then holds
    assign rdata_d = rd_en ? rd_val : rdata_q;

    // Sequencer: every access, transfer or plain, takes the same fixed path
    always_comb begin
        state_d = state_q;
        wait_d  = 1'h1;
        done_d  = 1'h0;
        case (state_q)
            ST_IDLE: begin
                // Stay here until a request shows
                if (req) begin
                    state_d = ST_FETCH;
                end
            end
            ST_FETCH: begin
                // Spare cycle for the registered control read
                state_d = ST_EXEC;
            end
            ST_EXEC: begin
                // Registers load at the end of this cycle
                state_d = ST_ACK;
                wait_d  = 1'h0;
                done_d  = op_ok;
            end
            ST_ACK: begin
                // Waitrequest is low while in this state
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // Sequencer flops
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            wait_q  <= 1'h1;
            done_q  <= 1'h0;
        end else if (ce) begin
            state_q <= state_d;
            wait_q  <= wait_d;
            done_q  <= done_d;
        end
    end

    // Readback and status flops
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= RST_DATA;
            op_q    <= op_nop;
            err_q   <= 1'h0;
            cy_q    <= 1'h0;
        end else if (ce) begin
            rdata_q <= rdata_d;
            op_q    <= op_d;
            err_q   <= err_d;
            cy_q    <= cy_d;
        end
    end

    // Data flops
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            acc_q <= RST_NIB;
            b_q   <= RST_NIB;
            e_q   <= RST_E;
            d_q   <= RST_D;
        end else if (ce) begin
            acc_q <= acc_d;
            b_q   <= b_d;
            e_q   <= e_d;
            d_q   <= d_d;
        end
    end

    // Pointer flops, loaded over the bus for now
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            x_q   <= RST_NIB;
            y_q   <= RST_NIB;
            z_q   <= RST_Z;
            sp_q  <= RST_D;
        end else if (ce) begin
            x_q   <= x_d;
            y_q   <= y_d;
            z_q   <= z_d;
            sp_q  <= sp_d;
        end
    end

    // Outputs straight from flops
    assign avs_readdata    = rdata_q;
    assign avs_waitrequest = wait_q;

    // Register exports for the rest of the core
    assign acc_val         = acc_q;
    assign b_val           = b_q;
    assign e_val           = e_q;
    assign d_ptr_val       = d_q;
    assign instr_done      = done_q;

endmodule : ate_xfer_exec

// ==== testbench/ate_xfer_exec_chk.sv ====
// Port-level assertions for the accumulator transfer executor
module ate_xfer_exec_chk
    import ate_pkg::*;
(
    input wire logic                clk_sys,
    input wire logic                rst_n,
    input wire logic                ce,
    input wire logic [ADDR_W-1:0]   avs_address,
    input wire logic                avs_read,
    input wire logic                avs_write,
    input wire logic [DATA_W-1:0]   avs_writedata,
    input wire logic                avs_waitrequest,
    input wire logic [ACC_W-1:0]    acc_val,
    input wire logic [ACC_W-1:0]    b_val,
    input wire logic [E_W-1:0]      e_val,
    input wire logic [D_W-1:0]      d_ptr_val,
    input wire logic                instr_done
);
    timeunit 1ns;
    timeprecision 1ps;

    // Opcode write decode seen from the bus side
    wire             req_on = avs_read || avs_write;
    wire             op_wr  = avs_write && (avs_address == ADR_OPCODE);
    wire [OP_W-1:0]  opc    = avs_writedata[OP_W-1:0];
    wire             wr_grp = op_wr && (opc >= 5'h05) && (opc != 5'h08) && (opc <= 5'h18)
                              && !((opc > 5'h08) && (opc < 5'h10));

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n || !ce);

    // Three wait cycles, then one answer cycle
    sequence wait3_s;
        avs_waitrequest [*3];
    endsequence
    sequence answer_s;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence

    ack_latency_a: assert property (req_on && !$past(req_on) |-> wait3_s ##1 answer_s)
        else $error("access answered at the wrong cycle");
    idle_wait_a: assert property (!req_on |-> avs_waitrequest)
        else $error("waitrequest low without a request");
    done_in_ack_a: assert property (instr_done |-> !avs_waitrequest && op_wr)
        else $error("instruction done outside an opcode ack");
    b_copy_a: assert property (instr_done && opc == op_write_b_reg |-> b_val == acc_val)
        else $error("register B does not hold the accumulator");
    e_pack_a: assert property (instr_done && opc == op_write_e_reg |-> e_val == {b_val, acc_val})
        else $error("register E is not B over accumulator");
    d_low_a: assert property (instr_done && opc == op_write_d_pointer |-> d_ptr_val == acc_val[2:0])
        else $error("D pointer is not accumulator bits 2..0");
    sp_top_a: assert property (instr_done && opc == op_read_stack_ptr |=> acc_val[3] == 1'b0)
        else $error("accumulator bit 3 not cleared by stack pointer read");
    z_top_a: assert property (instr_done && opc == op_read_z_pointer |=> acc_val[3:2] == 2'b00)
        else $error("accumulator bits 3..2 not cleared by Z read");
    acc_keep_a: assert property (instr_done && wr_grp |-> $stable(acc_val))
        else $error("a write transfer changed the accumulator");
endmodule : ate_xfer_exec_chk

bind ate_xfer_exec ate_xfer_exec_chk u_chk (
    .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
    .acc_val(acc_val), .b_val(b_val), .e_val(e_val), .d_ptr_val(d_ptr_val),
    .instr_done(instr_done)
);

// ==== testbench/tb.sv ====
// Self-checking bench for the accumulator transfer executor
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ate_pkg::*;

    logic              clk_sys, rst_n, ce, avs_read, avs_write, avs_waitrequest;
    logic              instr_done, done_q;
    logic [ADDR_W-1:0] avs_address;
    logic [DATA_W-1:0] avs_writedata, avs_readdata, rd;
    logic [3:0]        avs_byteenable;
    logic [ACC_W-1:0]  acc_val, b_val;
    logic [E_W-1:0]    e_val;
    logic [D_W-1:0]    d_ptr_val;
    int                n_mismatch, check_count;

    ate_xfer_exec u_ate_xfer_exec (
        .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .acc_val(acc_val), .b_val(b_val),
        .e_val(e_val), .d_ptr_val(d_ptr_val), .instr_done(instr_done)
    );

    // 250 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic complete_run;
        if (n_mismatch == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : complete_run

    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One Avalon access; held until waitrequest is sampled low
    // A hang is left to the watchdog
    task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_sys);
        avs_address   <= a;
        avs_writedata <= d;
        avs_read      <= !w;
        avs_write     <= w;
        do begin
            @(posedge clk_sys);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        done_q = instr_done;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
    endtask : rdchk

    task automatic exec(input logic [OP_W-1:0] op);
        wr(ADR_OPCODE, 32'(op));
        chk(32'(done_q), 32'h0000_0001);
    endtask : exec

    task automatic t_reset;
        rdchk(ADR_ACC, 32'h0000_0000);
        rdchk(ADR_STATUS, 32'h0000_0000);
        rdchk(ADR_CTL_LAST, 32'h0000_0000);
        wr(6'h3f, 32'h0000_000f);
        rdchk(6'h3f, 32'h0000_0000);
    endtask : t_reset

    task automatic t_ptr_reads;
        wr(ADR_X, 32'h0000_000a);
        exec(op_read_x_pointer);
        rdchk(ADR_ACC, 32'h0000_000a);
        wr(ADR_Y, 32'h0000_0005);
        exec(op_read_y_pointer);
        chk(32'(acc_val), 32'h0000_0005);
        wr(ADR_ACC, 32'h0000_000f);
        wr(ADR_SP, 32'h0000_0007);
        exec(op_read_stack_ptr);
        rdchk(ADR_ACC, 32'h0000_0007);
        wr(ADR_ACC, 32'h0000_000f);
        wr(ADR_Z, 32'h0000_0001);
        exec(op_read_z_pointer);
        rdchk(ADR_ACC, 32'h0000_0001);
    endtask : t_ptr_reads

    task automatic t_acc_writes;
        wr(ADR_ACC, 32'h0000_000d);
        exec(op_write_d_pointer);
        chk(32'(d_ptr_val), 32'h0000_0005);
        exec(op_write_b_reg);
        rdchk(ADR_B, 32'h0000_000d);
        wr(ADR_ACC, 32'h0000_0006);
        exec(op_write_e_reg);
        rdchk(ADR_E, 32'h0000_00d6);
        // Byte lane 0 disabled: the write must be dropped
        avs_byteenable <= 4'h0;
        wr(ADR_B, 32'h0000_0003);
        avs_byteenable <= 4'hf;
        chk(32'(b_val), 32'h0000_000d);
    endtask : t_acc_writes

    // Clock enable low: a pending write must neither advance nor land
    task automatic t_freeze;
        @(posedge clk_sys);
        ce            <= 1'b0;
        avs_address   <= ADR_B;
        avs_writedata <= 32'h0000_0009;
        avs_write     <= 1'b1;
        repeat (6) @(posedge clk_sys);
        chk(32'(avs_waitrequest), 32'h0000_0001);
        chk(32'(b_val), 32'h0000_000d);
        ce <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        chk(32'(b_val), 32'h0000_0009);
    endtask : t_freeze

    // Every write-to-control opcode, each with its own value
    task automatic t_ctl_writes;
        logic [3:0] v;
        for (int k = 0; k < 9; k++) begin
            v = 4'(12 - k);
            wr(ADR_ACC, 32'(v));
            exec(5'(16 + k));
            rdchk(ADR_CTL_BASE + 6'(8 + k), 32'(v));
        end
    endtask : t_ctl_writes

    // Every read-from-control opcode
    task automatic t_ctl_reads;
        logic [3:0] v;
        for (int k = 0; k < 8; k++) begin
            v = 4'(k + 3);
            wr(ADR_CTL_BASE + 6'(k), 32'(v));
            wr(ADR_ACC, 32'h0000_0000);
            exec(5'(8 + k));
            rdchk(ADR_ACC, 32'(v));
        end
    endtask : t_ctl_reads

    // Carry survives transfers, skip stays clear, bad opcode flags with no done pulse
    task automatic t_flags;
        wr(ADR_STATUS, 32'h0000_0001);
        exec(op_write_b_reg);
        exec(op_read_x_pointer);
        rdchk(ADR_STATUS, 32'h0000_0001);
        wr(ADR_OPCODE, 32'h0000_001f);
        chk(32'(done_q), 32'h0000_0000);
        rdchk(ADR_STATUS, 32'h0000_0005);
        wr(ADR_STATUS, 32'h0000_0005);
        rdchk(ADR_STATUS, 32'h0000_0001);
        exec(op_nop);
        rdchk(ADR_OPCODE, 32'h0000_0000);
    endtask : t_flags

    // Watchdog: the whole run needs a few microseconds
    initial begin
        #50000;
        n_mismatch++;
        complete_run();
    end

    initial begin
        n_mismatch = 0;
        check_count = 0;
        rst_n = 1'b0;
        ce = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 6'h00;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'hf;
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        t_reset();
        t_ptr_reads();
        t_acc_writes();
        t_freeze();
        t_ctl_writes();
        t_ctl_reads();
        t_flags();
        complete_run();
    end
endmodule : tb
